//--- rtl/mfi_pkg.sv
// Purpose: shared constants for the timer and i2c interrupt flag/enable bank
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes:   two 8-bit flag/enable registers plus sticky status and mask registers
package mfi_pkg;
    localparam int unsigned ADDR_W   = 4;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned REG_W    = 8;
    localparam int unsigned NUM_EVT  = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TIMER1 = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_TIMER3 = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 4'hc;

    // field positions; P and A fields shared by both flag/enable registers, the i2c pair used by timer3 only
    localparam int unsigned BIT_P_EN   = 0;
    localparam int unsigned BIT_A_EN   = 1;
    localparam int unsigned BIT_I2C_EN = 2;
    localparam int unsigned BIT_P_FLAG = 4;
    localparam int unsigned BIT_A_FLAG = 5;
    localparam int unsigned BIT_I2C_FL = 6;

    // implemented bits of each register; everything else reads zero
    localparam logic [REG_W-1:0] IMPL_TIMER1 = 8'h33;
    localparam logic [REG_W-1:0] IMPL_TIMER3 = 8'h77;
    localparam logic [REG_W-1:0] REG_RESET   = 8'h00;

    // event index in status/mask: t1p, t1a, t3p, t3a, i2c
    localparam int unsigned EVT_T1P = 0;
    localparam int unsigned EVT_T1A = 1;
    localparam int unsigned EVT_T3P = 2;
    localparam int unsigned EVT_T3A = 3;
    localparam int unsigned EVT_I2C = 4;
    localparam logic [NUM_EVT-1:0] EVT_RESET = 5'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/mfi_flag_cell.sv
// Purpose: one sticky request flag: hardware sets, software writes to change
// Assumes: event is a one-cycle or longer level in the aclk domain
// Notes:   set wins over a same-cycle software clear so no event is lost
`timescale 1ns/1ps
module mfi_flag_cell (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic event_in,
    input  wire logic wr_en,
    input  wire logic wr_val,
    output logic      flag
);
    // flag holds until software writes zero; event beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= 1'b0;
        end else if (event_in) begin
            flag <= 1'b1;
        end else if (wr_en) begin
            flag <= wr_val;
        end
    end
endmodule

//--- rtl/mfi_irq_bank.sv
// Purpose: axi4-lite slave holding timer1, timer3 and i2c interrupt flags and enables
// Assumes: event inputs synchronous to aclk; one outstanding read and one write
// Notes:   a flag drives its cpu request line only while its enable is high;
//          sticky status/mask registers feed the single level irq output
//          flags stay set until software writes zero; set beats clear
`timescale 1ns/1ps

// How it works
// - timer1 reg bit5: timer1 compare A flag
// - timer1 reg bit4: timer1 compare P flag
// - timer1 reg bit1: compare A enable
// - timer1 reg bit0: compare P enable
// - unimplemented bits read zero, ignore writes
// - flags stay set until software writes zero
// - timer3 reg bit6 i2c flag, bit2 enable
// - timer3 reg bits 0,1 enables; 4,5 flags
// - flags set always; requests gated by enable
module mfi_irq_bank
    import mfi_pkg::*;
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // peripheral events
    input  wire logic                         timer1_cmp_a_evt,
    input  wire logic                         timer1_cmp_p_evt,
    input  wire logic                         timer3_cmp_a_evt,
    input  wire logic                         timer3_cmp_p_evt,
    input  wire logic                         i2c_evt,
    // per-source requests toward the cpu interrupt logic
    output logic                              timer1_cmp_a_req,
    output logic                              timer1_cmp_p_req,
    output logic                              timer3_cmp_a_req,
    output logic                              timer3_cmp_p_req,
    output logic                              i2c_req,
    output logic                              irq,
    // axi4-lite write address
    input  wire logic [mfi_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    // write data
    input  wire logic [mfi_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [mfi_pkg::DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    // write response
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // read address
    input  wire logic [mfi_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    // read data
    output logic [mfi_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    import mfi_pkg::*;

    // register map, one 32-bit word each, payload in the low bits:
    //   0x0 timer one   b5 cmp A flag, b4 cmp P flag, b1 cmp A en, b0 cmp P en
    //   0x4 timer three b6 i2c flag, b5 cmp A flag, b4 cmp P flag
    //                   b2 i2c en, b1 cmp A en, b0 cmp P en
    //   0x8 status      sticky record of every event, write one to clear
    //   0xc mask        one bit per status bit, gates the irq line
    // status and mask bit order: t1 P, t1 A, t3 P, t3 A, i2c from bit 0 up
    // the flags are ordinary read/write bits that events also set; writing
    // zero is the only way to drop one, since servicing never clears them
    // status keeps a second copy of the same events so a polling driver can
    // clear it with write-one without touching the per-source flags
    // a write answers on the edge after both address and data are held, a read
    // on the same edge that takes its address; one of each in flight at most
    // unmapped addresses answer slverr and change nothing; a write with byte
    // lane 0 off answers okay and changes nothing, since every field is there

    // elaboration guard: the read mux zero-fills above one register, so the
    // bus must be one 32-bit word and the event vector must fit a register
    if (DATA_W != 32 || REG_W > DATA_W || NUM_EVT > REG_W) begin : g_bad_width
        $error("mfi_irq_bank: unsupported width settings");
    end

    // write channel capture
    logic                  aw_held;
    logic                  w_held;
    logic [ADDR_W-1:0]     aw_addr;
    logic [DATA_W-1:0]     w_data;
    logic [DATA_W/8-1:0]   w_strb;
    logic                  wr_fire;
    logic                  wr_lane0;

    // enable bits, one per source
    logic                  t1_a_en;
    logic                  t1_p_en;
    logic                  t3_a_en;
    logic                  t3_p_en;
    logic                  i2c_en;
    // event strobes, flag cells and their write controls
    logic [NUM_EVT-1:0]    evt_vec;
    logic [NUM_EVT-1:0]    flag_vec;
    logic [NUM_EVT-1:0]    flag_wr;
    logic [NUM_EVT-1:0]    flag_val;
    // sticky status and its mask
    logic [NUM_EVT-1:0]    status;
    logic [NUM_EVT-1:0]    mask;
    // read images of the two flag/enable registers
    logic [REG_W-1:0]      t1_reg;
    logic [REG_W-1:0]      t3_reg;
    // per-source enables in event order, and the gated requests
    logic [NUM_EVT-1:0]    en_vec;
    logic [NUM_EVT-1:0]    req_vec;
    // write selects, decoded once and shared by every register that listens
    logic                  wr_t1;
    logic                  wr_t3;
    logic                  wr_status;
    logic                  wr_mask;
    // read mux output, registered into rdata
    logic [DATA_W-1:0]     next_rdata;

    // decode used by both read and write paths
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == OFS_TIMER1) || (a == OFS_TIMER3) ||
                      (a == OFS_STATUS) || (a == OFS_MASK);
    endfunction

    // address and data may arrive in either order; each is held until both are in
    // ready is combinational from held state so it drops right after its item
    // is taken; bvalid blocks both channels until the response is accepted,
    // which keeps a single write in flight
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0      = wr_fire && w_strb[0] && addr_mapped(aw_addr);
    assign wr_t1         = wr_lane0 && (aw_addr == OFS_TIMER1);
    assign wr_t3         = wr_lane0 && (aw_addr == OFS_TIMER3);
    assign wr_status     = wr_lane0 && (aw_addr == OFS_STATUS);
    assign wr_mask       = wr_lane0 && (aw_addr == OFS_MASK);

    // write address capture, released once the write fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // write data capture, released once the write fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // write response; unmapped addresses answer slverr and change nothing
    // bresp comes from the held address, so it always matches the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // reset to zero
    // enables move only on a write to their own register with byte lane 0 on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t1_a_en <= 1'b0;
            t1_p_en <= 1'b0;
        end else if (wr_t1) begin
            t1_a_en <= w_data[BIT_A_EN];
            t1_p_en <= w_data[BIT_P_EN];
        end
    end

    // timer three enables
    // the timer three register adds the i2c pair at bits 6 and 2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t3_a_en <= 1'b0;
            t3_p_en <= 1'b0;
            i2c_en  <= 1'b0;
        end else if (wr_t3) begin
            t3_a_en <= w_data[BIT_A_EN];
            t3_p_en <= w_data[BIT_P_EN];
            i2c_en  <= w_data[BIT_I2C_EN];
        end
    end

    // events set flags regardless of enable
    assign evt_vec[EVT_T1P] = timer1_cmp_p_evt;
    assign evt_vec[EVT_T1A] = timer1_cmp_a_evt;
    assign evt_vec[EVT_T3P] = timer3_cmp_p_evt;
    assign evt_vec[EVT_T3A] = timer3_cmp_a_evt;
    assign evt_vec[EVT_I2C] = i2c_evt;

    // timer1 and timer3 flag writes
    // a write replaces the flag; a same-cycle event still wins in the cell
    assign flag_wr[EVT_T1P]  = wr_t1;
    assign flag_wr[EVT_T1A]  = wr_t1;
    assign flag_val[EVT_T1P] = w_data[BIT_P_FLAG];
    assign flag_val[EVT_T1A] = w_data[BIT_A_FLAG];
    assign flag_wr[EVT_T3P]  = wr_t3;
    assign flag_wr[EVT_T3A]  = wr_t3;
    assign flag_wr[EVT_I2C]  = wr_t3;
    assign flag_val[EVT_T3P] = w_data[BIT_P_FLAG];
    assign flag_val[EVT_T3A] = w_data[BIT_A_FLAG];
    assign flag_val[EVT_I2C] = w_data[BIT_I2C_FL];

    // flags held until written zero
    // one cell per source; the cell settles set against clear
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : g_flag
            mfi_flag_cell u_flag (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .event_in (evt_vec[gi]),
                .wr_en    (flag_wr[gi]),
                .wr_val   (flag_val[gi]),
                .flag     (flag_vec[gi])
            );
        end
    endgenerate

    // sticky status: set by events, cleared by writing one; set wins so an
    // event landing on the clear is never lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= EVT_RESET;
        end else if (wr_status) begin
            status <= (status & ~w_data[NUM_EVT-1:0]) | evt_vec;
        end else begin
            status <= status | evt_vec;
        end
    end

    // mask is plain read/write; bits above the event count are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask <= EVT_RESET;
        end else if (wr_mask) begin
            mask <= w_data[NUM_EVT-1:0];
        end
    end

    // enables in event order, matching flag_vec bit for bit
    assign en_vec[EVT_T1P] = t1_p_en;
    assign en_vec[EVT_T1A] = t1_a_en;
    assign en_vec[EVT_T3P] = t3_p_en;
    assign en_vec[EVT_T3A] = t3_a_en;
    assign en_vec[EVT_I2C] = i2c_en;

    // request only while enabled
    // combinational, so a request drops in the cycle its enable clears
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : g_req
            assign req_vec[gi] = flag_vec[gi] && en_vec[gi];
        end
    endgenerate

    assign timer1_cmp_a_req = req_vec[EVT_T1A];
    assign timer1_cmp_p_req = req_vec[EVT_T1P];
    assign timer3_cmp_a_req = req_vec[EVT_T3A];
    assign timer3_cmp_p_req = req_vec[EVT_T3P];
    assign i2c_req          = req_vec[EVT_I2C];

    // level irq, high while any unmasked status bit is set
    // the mask acts only here, so masking never loses a status bit
    assign irq = |(status & mask);

    // unimplemented bits read zero
    // timer one image; bits 7..6 and 3..2 stay zero
    always_comb begin
        t1_reg             = REG_RESET;
        t1_reg[BIT_A_FLAG] = flag_vec[EVT_T1A];
        t1_reg[BIT_P_FLAG] = flag_vec[EVT_T1P];
        t1_reg[BIT_A_EN]   = t1_a_en;
        t1_reg[BIT_P_EN]   = t1_p_en;
        t1_reg             = t1_reg & IMPL_TIMER1;
    end

    // timer three image; bits 7 and 3 stay zero
    always_comb begin
        t3_reg             = REG_RESET;
        t3_reg[BIT_I2C_FL] = flag_vec[EVT_I2C];
        t3_reg[BIT_A_FLAG] = flag_vec[EVT_T3A];
        t3_reg[BIT_P_FLAG] = flag_vec[EVT_T3P];
        t3_reg[BIT_I2C_EN] = i2c_en;
        t3_reg[BIT_A_EN]   = t3_a_en;
        t3_reg[BIT_P_EN]   = t3_p_en;
        t3_reg             = t3_reg & IMPL_TIMER3;
    end

    // read channel: one read at a time, data registered
    // arready drops while an answer waits, so the mux never holds an address
    // of its own; the cost is a dead cycle between back-to-back reads
    assign s_axi_arready = !s_axi_rvalid;

    // read mux, decoded apart from the response flop; unmapped reads give zero
    // status and mask are narrower than a register and zero-fill the same way
    always_comb begin
        next_rdata = '0;
        case (s_axi_araddr)
            OFS_TIMER1: next_rdata = {{(DATA_W-REG_W){1'b0}}, t1_reg};
            OFS_TIMER3: next_rdata = {{(DATA_W-REG_W){1'b0}}, t3_reg};
            OFS_STATUS: next_rdata = {{(DATA_W-NUM_EVT){1'b0}}, status};
            OFS_MASK:   next_rdata = {{(DATA_W-NUM_EVT){1'b0}}, mask};
            default:    next_rdata = '0;
        endcase
    end

    // read response flop; rvalid, rdata and rresp stand until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata  <= next_rdata;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

//--- testbench/mfi_evt_src.sv
// Purpose: peripheral event sources standing beside the irq bank
// Assumes: the bench asks for events one cycle ahead through fire
// Notes:   each event is a one-cycle strobe, like a compare match
`timescale 1ns/1ps
module mfi_evt_src (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [4:0] fire,
    output logic      [4:0] evt
);
    // registered so strobes never change on the design's sampling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt <= 5'h00;
        end else begin
            evt <= fire;
        end
    end
endmodule

//--- testbench/mfi_irq_bank_sva.sv
// Purpose: port-level assertions for the irq flag/enable bank
// Assumes: single aclk domain, synchronous active-low reset
// Notes:   flag contents are judged by the bench; here timing and holds
`timescale 1ns/1ps
module mfi_irq_bank_chk
    import mfi_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              timer1_cmp_a_evt,
    input wire logic              timer1_cmp_a_req,
    input wire logic              i2c_req,
    input wire logic              irq,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // irq, the timer1 cmp A and i2c requests, bvalid and rvalid low on the first edge after reset
    reset_clear_a: assert property ($rose(aresetn) |-> !irq && !timer1_cmp_a_req && !i2c_req
        && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not clear after reset");
    // a request only rises from its event or a register write in flight
    req_rise_a: assert property ($rose(timer1_cmp_a_req) |-> $past(timer1_cmp_a_evt)
        || !$past(s_axi_wready) || !$past(s_axi_wready, 2)) else $error("request rose uncaused");
    // only software can drop a pending request
    req_fall_a: assert property ($fell(timer1_cmp_a_req) |->
        !$past(s_axi_wready) || !$past(s_axi_wready, 2)) else $error("request dropped alone");
    read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("unimplemented bits read nonzero");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response not held");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(irq));
endmodule
bind mfi_irq_bank mfi_irq_bank_chk i_chk (.aclk(aclk), .aresetn(aresetn),
    .timer1_cmp_a_evt(timer1_cmp_a_evt), .timer1_cmp_a_req(timer1_cmp_a_req),
    .i2c_req(i2c_req), .irq(irq), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

//--- testbench/test_multifunction_irq_flag_enable_bank.sv
// Purpose: register-level bench for the irq flag/enable bank
// Assumes: axi4-lite master tasks, events from the source model
// Notes:   every wait is bounded; a hang ends in the closing report
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_multifunction_irq_flag_enable_bank;
    import mfi_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [4:0]  fire, evt;
    wire  [4:0]  req;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    int          n_errors, n_checks;
    mfi_evt_src i_src (.aclk(aclk), .aresetn(aresetn), .fire(fire), .evt(evt));
    mfi_irq_bank i_dut (.aclk(aclk), .aresetn(aresetn), .timer1_cmp_a_evt(evt[1]),
        .timer1_cmp_p_evt(evt[0]), .timer3_cmp_a_evt(evt[3]), .timer3_cmp_p_evt(evt[2]),
        .i2c_evt(evt[4]), .timer1_cmp_a_req(req[1]), .timer1_cmp_p_req(req[0]),
        .timer3_cmp_a_req(req[3]), .timer3_cmp_p_req(req[2]), .i2c_req(req[4]), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // write one word; aw and w released independently as each is taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er = RESP_OKAY);
        bit done;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                `CHK("bresp", er, bresp)
            end
        end
        if (!done) begin
            $display("mismatch bvalid expected 1 seen 0");
            n_errors++;
            end_of_test();
        end
    endtask
    // read one word and compare it with the expected value
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm,
                      input logic [1:0] er = RESP_OKAY);
        bit done;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
                `CHK(nm, e, rdata)
                `CHK("rresp", er, rresp)
            end
        end
        if (!done) begin
            $display("mismatch rvalid expected 1 seen 0");
            n_errors++;
            end_of_test();
        end
    endtask
    // one request to the source model; settle two edges before looking
    task automatic pulse(input logic [4:0] m);
        @(posedge aclk);
        fire <= m;
        @(posedge aclk);
        fire <= 5'h00;
        repeat (2) @(posedge aclk);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wstrb, wdata, fire} = '0;
        n_errors = 0;
        n_checks = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0000_0000, "reset value");
        $display("test reset values done");
        wr(OFS_TIMER1, 32'hffff_ffff, 4'hf);
        rd(OFS_TIMER1, 32'h0000_0033, "timer1 reg");
        wr(OFS_TIMER3, 32'hffff_ffff, 4'hf);
        rd(OFS_TIMER3, 32'h0000_0077, "timer3 reg");
        `CHK("requests", 5'h1f, req)
        wr(OFS_TIMER1, 32'h0000_0000, 4'hf);
        wr(OFS_TIMER3, 32'h0000_0000, 4'hf);
        wr(OFS_TIMER1, 32'h0000_00ff, 4'h0);
        rd(OFS_TIMER1, 32'h0000_0000, "strobe off");
        $display("test implemented bits done");
        pulse(5'h1f);
        `CHK("requests", 5'h00, req)
        rd(OFS_TIMER1, 32'h0000_0030, "timer1 flags");
        rd(OFS_TIMER3, 32'h0000_0070, "timer3 flags");
        repeat (20) @(posedge aclk);
        rd(OFS_TIMER1, 32'h0000_0030, "flags kept");
        wr(OFS_TIMER1, 32'h0000_0032, 4'h1);
        `CHK("requests", 5'h02, req)
        wr(OFS_TIMER1, 32'h0000_0031, 4'h1);
        `CHK("requests", 5'h01, req)
        wr(OFS_TIMER3, 32'h0000_0074, 4'h1);
        `CHK("requests", 5'h11, req)
        wr(OFS_TIMER3, 32'h0000_0073, 4'h1);
        `CHK("requests", 5'h0d, req)
        wr(OFS_TIMER1, 32'h0000_0001, 4'h1);
        `CHK("requests", 5'h0c, req)
        $display("test flags and enables done");
        rd(OFS_STATUS, 32'h0000_001f, "status");
        `CHK("irq masked", 1'b0, irq)
        wr(OFS_MASK, 32'h0000_0010, 4'h1);
        `CHK("irq raised", 1'b1, irq)
        wr(OFS_STATUS, 32'h0000_0010, 4'h1);
        `CHK("irq cleared", 1'b0, irq)
        rd(OFS_STATUS, 32'h0000_000f, "status after clear");
        $display("test interrupt line done");
        wr(4'h2, 32'h0000_001f, 4'h1, RESP_SLVERR);
        rd(4'h2, 32'h0000_0000, "unmapped", RESP_SLVERR);
        rd(OFS_MASK, 32'h0000_0010, "mask untouched");
        $display("test unmapped address done");
        end_of_test();
    end
endmodule
